// file: src/eif_pkg.sv
// Purpose: shared constants and types for the ethernet interrupt flag block
// Assumes: 32-bit apb register bus, word aligned registers
// Notes:   offsets are byte addresses
package eif_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_FLAGS     = 8'h00;
  localparam logic [7:0] OFF_FLAGS_CLR = 8'h04;
  localparam logic [7:0] OFF_FLAGS_SET = 8'h08;
  localparam logic [7:0] OFF_FLAGS_INV = 8'h0C;
  localparam logic [7:0] OFF_WMARK     = 8'h10;
  localparam logic [7:0] OFF_CTRL      = 8'h14;
  localparam logic [7:0] OFF_STAT      = 8'h18;
  localparam logic [7:0] OFF_MASK      = 8'h1C;
  localparam logic [7:0] OFF_PEND      = 8'h20;
  // flag bit positions
  localparam int BIT_TXBUS   = 14;
  localparam int BIT_RXBUS   = 13;
  localparam int BIT_EWM     = 9;
  localparam int BIT_FWM     = 8;
  localparam int BIT_RX_DONE_FLAG  = 7;
  localparam int BIT_PACKET_PENDING_FLAG = 6;
  localparam int BIT_RX_ACTIVE_FLAG   = 5;
  localparam int BIT_TX_DONE_FLAG  = 3;
  localparam int BIT_TX_ABORT_FLAG = 2;
  localparam int BIT_RX_BUFFER_UNAVAILABLE_FLAG = 1;
  localparam int BIT_RXOVF   = 0;
  // implemented flag bits; the rest read zero
  localparam logic [31:0] FLAG_MASK   = 32'h0000_63EF;
  localparam logic [31:0] SW_MASK     = 32'h0000_60EF;
  localparam logic [31:0] FLAG_RESET  = 32'h0000_0000;
  // watermark config field positions
  localparam int EWM_LSB = 0;
  localparam int FWM_LSB = 16;
  localparam int CNT_LSB = 16;
  localparam int DEC_BIT = 0;
  localparam int CNT_W   = 8;
  // dma event carrier
  typedef struct packed {
    logic tx_bus_err;
    logic tx_done;
    logic tx_abort;
    logic rx_bus_err;
    logic rx_done;
    logic pkt_pend;
    logic rx_act;
    logic rx_bufna;
    logic rx_ovf;
    logic rx_buf_inc;
  } eif_evt_t;
endpackage

// file: src/eif_rx_buffer_counter.sv
// Purpose: receive descriptor buffer counter with watermark compares
// Assumes: increment from dma, decrement from software strobe
// Notes:   counter saturates at both ends
`timescale 1ns/1ps
module eif_rx_buffer_counter #(
  parameter int CW = eif_pkg::CNT_W
) (
  input  wire logic          pclk,     // system clock
  input  wire logic          presetn,  // async reset, low
  input  wire logic          inc,      // hardware increment
  input  wire logic          dec,      // software decrement
  input  wire logic [CW-1:0] ewm_thr,  // empty threshold
  input  wire logic [CW-1:0] fwm_thr,  // full threshold
  output logic      [CW-1:0] count,    // current count
  output logic               at_empty, // count <= empty threshold
  output logic               at_full   // count >= full threshold
);
  // refuse counter widths the compare ports cannot serve
  if (CW < 1 || CW > 16)
  begin : g_bad_cw
    $error("eif_rx_buffer_counter: CW out of range");
  end

  // count update, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (inc && !dec && count != {CW{1'b1}})
      count <= count + CW'(1);
    else if (dec && !inc && count != '0)
      count <= count - CW'(1);
  end

  // watermark compares
  assign at_empty = count <= ewm_thr;
  assign at_full  = count >= fwm_thr;
endmodule

// file: src/eif_top.sv
// Purpose: ethernet interrupt request flag register with apb access
// Assumes: dma events are single-cycle pulses synchronous to pclk
// Notes:   plain, clear, set and invert alias addresses reach the flags
`timescale 1ns/1ps

// Functional notes
// RULE1: tx dma bus error sets bit 14
// RULE2: rx dma bus error sets bit 13
// RULE3: bus error flags cleared by reset or clear alias
// RULE4: empty watermark set when count at/below threshold
// RULE5: empty watermark clears on hardware count increment
// RULE6: full watermark set when count at/above threshold
// RULE7: decrement control bit lowers count, clears full
// RULE8: software writes ignored on watermark flags
// RULE9: bits 31-15 and 12-10 read zero
// RULE10: tx flags from tx, others from rx
// RULE11: software should use set/clear/invert aliases
// RULE12: remaining flags at bits 7,6,5,3,2,1,0; 4 zero
module eif_top (
  input  wire logic              pclk,    // system clock
  input  wire logic              presetn, // async reset, low
  input  wire logic              psel,    // apb select
  input  wire logic              penable, // apb enable
  input  wire logic              pwrite,  // apb direction
  input  wire logic [7:0]        paddr,   // apb byte address
  input  wire logic [31:0]       pwdata,  // apb write data
  input  wire eif_pkg::eif_evt_t evt,     // dma event pulses
  output logic      [31:0]       prdata,  // apb read data
  output logic                   pready,  // apb ready
  output logic                   pslverr, // apb error
  output logic                   irq      // interrupt level
);
  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] mask_r;
  logic [31:0] pend_r;
  logic [7:0]  ewm_thr_r;
  logic [7:0]  fwm_thr_r;
  logic [7:0]  count;
  logic        at_empty;
  logic        at_full;
  logic        ewm_st_r;
  logic        fwm_st_r;
  logic        dec_req;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] hw_set;
  logic [31:0] pend_evt;

  // access phase decode; answers in the first access cycle
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && pready;
  assign rd     = psel && penable && !pwrite && pready;
  assign mapped = paddr <= eif_pkg::OFF_PEND && paddr[1:0] == 2'b00;
  assign dec_req = wr && paddr == eif_pkg::OFF_CTRL && pwdata[eif_pkg::DEC_BIT]; // RULE7

  // buffer counter and watermark compares
  eif_rx_buffer_counter #(
    .CW(eif_pkg::CNT_W)
  ) u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .inc      (evt.rx_buf_inc),
    .dec      (dec_req),
    .ewm_thr  (ewm_thr_r),
    .fwm_thr  (fwm_thr_r),
    .count    (count),
    .at_empty (at_empty),
    .at_full  (at_full)
  );

  // empty watermark: set on compare, cleared by hardware increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ewm_st_r <= 1'b0;
    else if (evt.rx_buf_inc)
      ewm_st_r <= 1'b0; // RULE5
    else if (at_empty)
      ewm_st_r <= 1'b1; // RULE4
  end

  // full watermark: set on compare, cleared by decrement strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fwm_st_r <= 1'b0;
    else if (dec_req)
      fwm_st_r <= 1'b0; // RULE7
    else if (at_full)
      fwm_st_r <= 1'b1; // RULE6
  end

  // hardware set terms; tx flags only from tx events
  always_comb
  begin
    hw_set = '0;
    hw_set[eif_pkg::BIT_TXBUS]   = evt.tx_bus_err; // RULE1 RULE10
    hw_set[eif_pkg::BIT_TX_DONE_FLAG]  = evt.tx_done;    // RULE10
    hw_set[eif_pkg::BIT_TX_ABORT_FLAG] = evt.tx_abort;   // RULE10
    hw_set[eif_pkg::BIT_RXBUS]   = evt.rx_bus_err; // RULE2
    hw_set[eif_pkg::BIT_RX_DONE_FLAG]  = evt.rx_done;    // RULE12
    hw_set[eif_pkg::BIT_PACKET_PENDING_FLAG] = evt.pkt_pend;   // RULE12
    hw_set[eif_pkg::BIT_RX_ACTIVE_FLAG]   = evt.rx_act;     // RULE12
    hw_set[eif_pkg::BIT_RX_BUFFER_UNAVAILABLE_FLAG] = evt.rx_bufna;   // RULE12
    hw_set[eif_pkg::BIT_RXOVF]   = evt.rx_ovf;     // RULE12
  end

  // software path then hardware set; set wins over clear
  always_comb
  begin
    flags_nxt = flags_r;
    if (wr)
    begin
      unique case (paddr)
        eif_pkg::OFF_FLAGS:
          flags_nxt = (flags_r & ~eif_pkg::SW_MASK) | (pwdata & eif_pkg::SW_MASK);
        eif_pkg::OFF_FLAGS_CLR:
          flags_nxt = flags_r & ~(pwdata & eif_pkg::SW_MASK); // RULE3 RULE8
        eif_pkg::OFF_FLAGS_SET:
          flags_nxt = flags_r | (pwdata & eif_pkg::SW_MASK);
        eif_pkg::OFF_FLAGS_INV:
          flags_nxt = flags_r ^ (pwdata & eif_pkg::SW_MASK);
        default:
          flags_nxt = flags_r;
      endcase
    end
    flags_nxt = (flags_nxt | hw_set) & eif_pkg::SW_MASK; // RULE9
    flags_nxt[eif_pkg::BIT_EWM] = ewm_st_r; // RULE8
    flags_nxt[eif_pkg::BIT_FWM] = fwm_st_r; // RULE8
  end

  // flag register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= eif_pkg::FLAG_RESET; // RULE3
    else
      flags_r <= flags_nxt;
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ewm_thr_r <= 8'h00;
      fwm_thr_r <= 8'hFF;
      mask_r    <= 32'h0000_0000;
    end
    else if (wr && paddr == eif_pkg::OFF_WMARK)
    begin
      ewm_thr_r <= pwdata[eif_pkg::EWM_LSB +: 8];
      fwm_thr_r <= pwdata[eif_pkg::FWM_LSB +: 8];
    end
    else if (wr && paddr == eif_pkg::OFF_MASK)
      mask_r <= pwdata & eif_pkg::FLAG_MASK;
  end

  // sticky pending: rising flags set, read clears only what it returned, set wins
  assign pend_evt = flags_nxt & ~flags_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= 32'h0000_0000;
    else if (rd && paddr == eif_pkg::OFF_PEND)
      pend_r <= (pend_r & ~prdata) | pend_evt; // bits raised after the capture survive
    else
      pend_r <= pend_r | pend_evt;
  end

  // interrupt output from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(pend_r & mask_r);
  end

  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      eif_pkg::OFF_FLAGS, eif_pkg::OFF_FLAGS_CLR, eif_pkg::OFF_FLAGS_SET, eif_pkg::OFF_FLAGS_INV:
        rd_val = flags_r & eif_pkg::FLAG_MASK; // RULE9
      eif_pkg::OFF_WMARK:
        rd_val = {8'h00, fwm_thr_r, 8'h00, ewm_thr_r};
      eif_pkg::OFF_STAT:
        rd_val = {8'h00, count, 16'h0000};
      eif_pkg::OFF_MASK:
        rd_val = mask_r;
      eif_pkg::OFF_PEND:
        rd_val = pend_r;
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  // apb answer registered in setup cycle, one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite && mapped) ? rd_val : 32'h0000_0000;
    end
  end

  // assertions: event flags and alias clear
  a_txbus_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    evt.tx_bus_err |=> flags_r[eif_pkg::BIT_TXBUS])
    else $error("tx bus error flag not set");
  a_rxbus_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    evt.rx_bus_err |=> flags_r[eif_pkg::BIT_RXBUS])
    else $error("rx bus error flag not set");
  a_clr_alias_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    wr && paddr == eif_pkg::OFF_FLAGS_CLR && pwdata[eif_pkg::BIT_TXBUS] && !evt.tx_bus_err
    |=> !flags_r[eif_pkg::BIT_TXBUS])
    else $error("clear alias did not clear tx bus error");
  a_hw_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    hw_set != 32'h0000_0000 |=> (flags_r & $past(hw_set)) == $past(hw_set))
    else $error("dma event lost against software write");

  // watermark flags follow the counter only
  a_ewm_follows: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    at_empty && !evt.rx_buf_inc |=> ##1 flags_r[eif_pkg::BIT_EWM])
    else $error("empty watermark not set");
  a_ewm_inc_clr: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    evt.rx_buf_inc |=> !ewm_st_r)
    else $error("empty watermark not cleared by increment");
  a_fwm_follows: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    at_full && !dec_req |=> ##1 flags_r[eif_pkg::BIT_FWM])
    else $error("full watermark not set");
  a_dec_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    dec_req |=> !fwm_st_r)
    else $error("decrement did not clear full watermark");
  a_dec_lowers: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    dec_req && !evt.rx_buf_inc && count != 8'h00 |=> count == $past(count) - 8'h01)
    else $error("decrement did not lower the buffer count");
  a_inc_raises: assert property (@(posedge pclk) disable iff (!presetn)
    evt.rx_buf_inc && !dec_req && count != 8'hFF |=> count == $past(count) + 8'h01)
    else $error("increment did not raise the buffer count");
  a_wm_sw_ignore: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    flags_r[eif_pkg::BIT_FWM] == $past(fwm_st_r))
    else $error("full watermark not following counter state");
  a_ewm_sw_ignore: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    flags_r[eif_pkg::BIT_EWM] == $past(ewm_st_r))
    else $error("empty watermark not following counter state");

  // unimplemented bits stay zero
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    pready && !pwrite && paddr == eif_pkg::OFF_FLAGS |-> (prdata & ~eif_pkg::FLAG_MASK) == 32'h0)
    else $error("unimplemented bits read nonzero");
  a_rsvd_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (flags_r & ~eif_pkg::FLAG_MASK) == 32'h0000_0000)
    else $error("unimplemented flag bit set");
  a_bit4_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    !flags_r[4] && !flags_r[12])
    else $error("reserved flag bit set");

  // apb answer shape
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pready && pslverr)
    else $error("refused access not flagged");
  a_err_no_data: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");

  // pending register and interrupt level
  a_pend_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    pend_evt != 32'h0000_0000 |=> (pend_r & $past(pend_evt)) == $past(pend_evt))
    else $error("rising flag missing from pending");
  a_pend_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == eif_pkg::OFF_PEND && pend_evt == 32'h0000_0000 |=> (pend_r & $past(prdata)) == 32'h0000_0000)
    else $error("pending read did not clear returned bits");
  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (|(pend_r & mask_r)) |=> irq)
    else $error("irq low with unmasked pending bit");
  a_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(pend_r & mask_r)) |=> !irq)
    else $error("irq high with nothing pending");

  // main scenarios reached
  c_txbus: cover property (@(posedge pclk) evt.tx_bus_err ##1 wr && paddr == eif_pkg::OFF_FLAGS_CLR);
  c_full_dec: cover property (@(posedge pclk) fwm_st_r ##[1:20] dec_req);
  c_irq: cover property (@(posedge pclk) irq ##[1:10] rd && paddr == eif_pkg::OFF_PEND);
  c_ewm_inc: cover property (@(posedge pclk) ewm_st_r ##1 evt.rx_buf_inc);
  c_refused: cover property (@(posedge pclk) pready && pslverr);
endmodule

// file: sim/eif_dma_model.sv
// Purpose: behavioural tx and rx dma engines feeding event pulses
// Assumes: bench raises one request vector for one cycle
// Notes:   each request becomes a one-cycle pulse on the event struct
`timescale 1ns/1ps
module eif_dma_model (
  input  wire logic        pclk,    // system clock
  input  wire logic        presetn, // async reset, low
  input  wire logic [9:0]  req,     // event request from bench
  output eif_pkg::eif_evt_t evt     // event pulses to block
);
  // tx fields come only from tx engine requests, rest from rx
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt <= '0;
    else
      evt <= eif_pkg::eif_evt_t'(req);
  end
endmodule

// file: sim/ethernet_irq_flags_tb.sv
// Purpose: self-checking bench for the interrupt flag block
// Assumes: apb master tasks, dma model on the event port
// Notes:   reset checks, table loop for single events, then hand-written cases
`timescale 1ns/1ps
module ethernet_irq_flags_tb;
  typedef struct packed
  {
    logic [9:0]  ev;
    logic [31:0] fl;
  } eif_row_t;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [9:0]        req;
  logic              e;
  eif_pkg::eif_evt_t evt;
  int                fail_count = 0;
  int                compares = 0;
  bit                hung = 1'b0;
  eif_row_t          rows [9] = '{'{10'h200, 32'h0000_4000}, '{10'h100, 32'h0000_0008},
    '{10'h080, 32'h0000_0004}, '{10'h040, 32'h0000_2000}, '{10'h020, 32'h0000_0080},
    '{10'h010, 32'h0000_0040}, '{10'h008, 32'h0000_0020}, '{10'h004, 32'h0000_0002},
    '{10'h002, 32'h0000_0001}};

  eif_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .evt(evt), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  eif_dma_model i_dma (.pclk(pclk), .presetn(presetn), .req(req), .evt(evt));

  // free-running 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("counts: compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer: setup, access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (hung)
      return;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      chk(32'h0, 32'h1, "pready timeout");
      hung = 1'b1;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp, "read data");
  endtask

  task automatic fire(input logic [9:0] v);
    @(posedge pclk);
    req <= v;
    @(posedge pclk);
    req <= '0;
    repeat (4) @(posedge pclk);
  endtask

  // main sequence
  initial
  begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // reset state, empty watermark and ignored writes
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0200);
    rd(eif_pkg::OFF_WMARK, 32'h00FF_0000);
    rd(eif_pkg::OFF_MASK, 32'h0000_0000);
    apb(1'b1, eif_pkg::OFF_FLAGS, 32'h0000_0000);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0200);
    apb(1'b1, eif_pkg::OFF_FLAGS_CLR, 32'h0000_0300);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0200);
    fire(10'h001);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0000);
    rd(eif_pkg::OFF_STAT, 32'h0001_0000);
    $display("test reset done");
    // each dma flag event (all but rx_buf_inc) lands on its own bit, clear alias removes it
    foreach (rows[i])
    begin
      fire(rows[i].ev);
      rd(eif_pkg::OFF_FLAGS, rows[i].fl);
      apb(1'b1, eif_pkg::OFF_FLAGS_CLR, 32'hFFFF_FFFF);
      rd(eif_pkg::OFF_FLAGS, 32'h0000_0000);
    end
    $display("test event table done");
    // set and invert aliases, unimplemented bits
    apb(1'b1, eif_pkg::OFF_FLAGS_SET, 32'hFFFF_FFFF);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_60EF);
    apb(1'b1, eif_pkg::OFF_FLAGS_INV, 32'h0000_2301);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_40EE);
    apb(1'b1, eif_pkg::OFF_FLAGS_CLR, 32'hFFFF_FFFF);
    $display("test aliases done");
    // full watermark set by count, cleared by decrement
    apb(1'b1, eif_pkg::OFF_WMARK, 32'h0002_0000);
    fire(10'h001);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0100);
    rd(eif_pkg::OFF_STAT, 32'h0002_0000);
    apb(1'b1, eif_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0000);
    rd(eif_pkg::OFF_STAT, 32'h0001_0000);
    $display("test full watermark done");
    // interrupt: masked event, unmasked event, read clears pending
    apb(1'b0, eif_pkg::OFF_PEND, 32'h0);
    rd(eif_pkg::OFF_PEND, 32'h0000_0000);
    apb(1'b1, eif_pkg::OFF_MASK, 32'h0000_4000);
    fire(10'h040);
    chk({31'h0, irq}, 32'h0, "masked irq");
    fire(10'h200);
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(eif_pkg::OFF_PEND, 32'h0000_6000);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after read");
    $display("test interrupt done");
    // refused accesses
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    apb(1'b1, 8'h02, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1, "misaligned error");
    rd(eif_pkg::OFF_FLAGS, 32'h0000_6000);
    $display("test refused done");
    // reset in mid-run brings flags, counter and mask back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd(eif_pkg::OFF_FLAGS, 32'h0000_0200);
    rd(eif_pkg::OFF_STAT, 32'h0000_0000);
    rd(eif_pkg::OFF_MASK, 32'h0000_0000);
    rd(eif_pkg::OFF_WMARK, 32'h00FF_0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
